// file: isa_map.svh
// Register offsets, field positions, reset values and bus codes of the status block
`ifndef ISA_MAP_SVH
`define ISA_MAP_SVH
// Register indices on the plain port
`define ISA_OFF_STATUS 3'h0
`define ISA_OFF_MASK   3'h1
`define ISA_OFF_CTRL   3'h2
`define ISA_OFF_SADDR  3'h3
`define ISA_OFF_TX     3'h4
`define ISA_OFF_RX     3'h5
// Status field positions
`define ISA_ST_ACK   15
`define ISA_ST_TRS   14
`define ISA_ST_BCL   10
`define ISA_ST_GC    9
`define ISA_ST_A10   8
`define ISA_ST_WCOL  7
`define ISA_ST_OV    6
`define ISA_ST_DA    5
`define ISA_ST_HALT  4
`define ISA_ST_BEGIN 3
`define ISA_ST_RW    2
`define ISA_ST_RBF   1
`define ISA_ST_TBF   0
// Control field positions
`define ISA_CT_TEN   0
`define ISA_CT_GENERAL_CALL_ENABLE  1
// Reset values and bus codes
`define ISA_MASK_RST  10'h000
`define ISA_SADDR_RST 10'h000
`define ISA_GC_ADDR   8'h00
`define ISA_TEN_PFX   5'h1E
`define ISA_BIT_LAST  4'h7
`define ISA_BIT_ACK   4'h8
`define ISA_BIT_END   4'h9
`endif

// file: isa_pkg.sv
// Types shared by the status and address mask block
package isa_pkg;
	// Slave address walk, Gray along idle-addr-addr2-data
	typedef enum logic [2:0] {
		ISA_IDLE  = 3'h0,
		ISA_ADDR  = 3'h1,
		ISA_ADDR2 = 3'h3,
		ISA_DATA  = 3'h2,
		ISA_SKIP  = 3'h6
	} isa_slave_t;
endpackage

// file: isa_status.sv
// Status flags, address mask matching and byte capture of the two-wire controller
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "isa_map.svh"
module isa_status (
	input  wire logic        core_clk,      // System clock, 100 MHz
	input  wire logic        reset,         // Async, active high
	input  wire logic [2:0]  reg_addr,      // Register index
	input  wire logic [15:0] reg_wdata,     // Write data
	input  wire logic        reg_wr,        // Write strobe
	input  wire logic        reg_rd,        // Read strobe
	output logic      [15:0] reg_rdata,     // Read data, cycle after strobe
	input  wire logic        scl_in,        // Bus clock pin level
	input  wire logic        sda_in,        // Bus data pin level
	output logic             sda_out,       // Data pin drive value, always low
	output logic             sda_oe,        // High while pulling data low
	output logic             rx_pulse,      // One cycle: byte moved to buffer
	output logic             gcall_pulse,   // One cycle: general call taken
	output isa_pkg::isa_slave_t slave_state // Slave address walk state
);
	import isa_pkg::*;

	// Pin synchronisers and edge history
	logic [1:0] scl_sync_r, sda_sync_r;
	logic       scl_old_r, sda_old_r;
	// Software-visible storage
	logic [9:0] address_mask_r, saddr_r;
	logic [1:0] ctrl_r;
	logic [7:0] receive_buffer_r, rx_sh_r, tx_sh_r;
	// Status flags
	logic ack_r, trs_r, bcl_r, gc_r, a10_r, wcol_r, ov_r, da_r;
	logic halt_r, begin_r, rw_r, rbf_r, tbf_r;
	logic [3:0] bitcnt_r;
	isa_slave_t st_r;

	// Decoded bus events, each seen in the cycle the second sync stage takes the new level
	wire scl_s     = scl_sync_r[1];
	wire sda_s     = sda_sync_r[1];
	wire scl_rise  = scl_s & ~scl_old_r;
	wire scl_fall  = ~scl_s & scl_old_r;
	wire start_det = scl_s & scl_old_r & sda_old_r & ~sda_s;
	wire stop_det  = scl_s & scl_old_r & ~sda_old_r & sda_s;
	wire byte_done = scl_rise & (bitcnt_r == `ISA_BIT_LAST);
	wire ack_rise  = scl_rise & (bitcnt_r == `ISA_BIT_ACK);
	wire ack_end   = scl_fall & (bitcnt_r == `ISA_BIT_END);
	wire [7:0] byte_in = {rx_sh_r[6:0], sda_s};

	// Register strobes
	wire wr_status = reg_wr & (reg_addr == `ISA_OFF_STATUS);
	wire wr_tx     = reg_wr & (reg_addr == `ISA_OFF_TX);
	wire rd_rx     = reg_rd & (reg_addr == `ISA_OFF_RX);
	// Transmitter busy: a byte is still queued or on the wire
	wire busy      = trs_r | tbf_r;
	wire tx_take   = wr_tx & ~busy;
	wire tx_reject = wr_tx & busy;

	// Collision: we released the line but another party holds it low
	wire collide   = trs_r & scl_rise & ~bitcnt_r[3] & ~sda_oe & ~sda_s;

	// Masked address compares; a one in the mask ignores that bit
	wire ten_mode  = ctrl_r[`ISA_CT_TEN];
	wire gc_en     = ctrl_r[`ISA_CT_GENERAL_CALL_ENABLE];
	wire m7_hit    = ((byte_in[7:1] ^ saddr_r[6:0]) & ~address_mask_r[6:0]) == 7'h00;
	wire m10_hi    = (byte_in[7:3] == `ISA_TEN_PFX) &&
	                 (((byte_in[2:1] ^ saddr_r[9:8]) & ~address_mask_r[9:8]) == 2'h0);
	wire m10_lo    = ((byte_in ^ saddr_r[7:0]) & ~address_mask_r[7:0]) == 8'h00;
	wire gc_hit    = gc_en & (byte_in == `ISA_GC_ADDR);
	wire slave_on  = ~trs_r;
	wire in_addr   = slave_on & byte_done & (st_r == ISA_ADDR);
	wire in_addr2  = slave_on & byte_done & (st_r == ISA_ADDR2);
	wire in_data   = slave_on & byte_done & (st_r == ISA_DATA);
	wire addr_ok   = in_addr & ~gc_hit & (ten_mode ? m10_hi : m7_hit);
	wire addr2_ok  = in_addr2 & m10_lo;
	wire rx_store  = in_data & ~rw_r;

	// Status read image, unused bits zero
	wire [15:0] status_img = {ack_r, trs_r, 3'h0, bcl_r, gc_r, a10_r,
	                          wcol_r, ov_r, da_r, halt_r, begin_r, rw_r, rbf_r, tbf_r};
	// Read mux
	wire [15:0] rd_mux =
		(reg_addr == `ISA_OFF_STATUS) ? status_img :
		(reg_addr == `ISA_OFF_MASK)   ? {6'h00, address_mask_r} :
		(reg_addr == `ISA_OFF_CTRL)   ? {14'h0000, ctrl_r} :
		(reg_addr == `ISA_OFF_SADDR)  ? {6'h00, saddr_r} :
		(reg_addr == `ISA_OFF_RX)     ? {8'h00, receive_buffer_r} : 16'h0000;

	// Software clears: writing zero to a clearable flag clears it
	wire clr_bcl   = wr_status & ~reg_wdata[`ISA_ST_BCL];
	wire clr_wcol  = wr_status & ~reg_wdata[`ISA_ST_WCOL];
	wire clr_ov    = wr_status & ~reg_wdata[`ISA_ST_OV];
	wire clr_halt  = wr_status & ~reg_wdata[`ISA_ST_HALT];
	wire clr_begin = wr_status & ~reg_wdata[`ISA_ST_BEGIN];

	// Two-flop synchronisers; only the second stage is read by logic
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_old_r  <= 1'b1;
			sda_old_r  <= 1'b1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], scl_in};
			sda_sync_r <= {sda_sync_r[0], sda_in};
			scl_old_r  <= scl_s;
			sda_old_r  <= sda_s;
		end
	end

	// Software registers and read data
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			address_mask_r <= `ISA_MASK_RST;
			saddr_r        <= `ISA_SADDR_RST;
			ctrl_r         <= 2'h0;
			reg_rdata      <= 16'h0000;
		end else begin
			if (reg_wr & (reg_addr == `ISA_OFF_MASK))
				address_mask_r <= reg_wdata[9:0];
			if (reg_wr & (reg_addr == `ISA_OFF_CTRL))
				ctrl_r <= reg_wdata[1:0];
			if (reg_wr & (reg_addr == `ISA_OFF_SADDR))
				saddr_r <= reg_wdata[9:0];
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// Bit counter: 0..7 data bits, 8 ack clock, 9 until ack ends
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			bitcnt_r <= 4'h0;
			rx_sh_r  <= 8'h00;
		end else if (start_det | stop_det) begin
			bitcnt_r <= 4'h0;
		end else if (scl_rise & (bitcnt_r <= `ISA_BIT_ACK)) begin
			bitcnt_r <= bitcnt_r + 4'h1;
			rx_sh_r  <= byte_in;
		end else if (ack_end) begin
			bitcnt_r <= 4'h0;
		end
	end

	// Master transmitter: drives the byte, releases for the ack
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			trs_r   <= 1'b0;
			tbf_r   <= 1'b0;
			ack_r   <= 1'b0;
			tx_sh_r <= 8'h00;
			sda_oe  <= 1'b0;
		end else if (collide | stop_det) begin
			// Lost arbitration or bus ended: let go at once
			trs_r  <= 1'b0;
			tbf_r  <= 1'b0;
			sda_oe <= 1'b0;
		end else if (tx_take) begin
			trs_r   <= 1'b1;
			tbf_r   <= 1'b1;
			tx_sh_r <= reg_wdata[7:0];
			sda_oe  <= ~reg_wdata[7];
		end else if (trs_r & scl_fall & (bitcnt_r < `ISA_BIT_ACK) & (bitcnt_r != 4'h0)) begin
			tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			sda_oe  <= ~tx_sh_r[6];
		end else if (trs_r & scl_fall & (bitcnt_r == `ISA_BIT_ACK)) begin
			sda_oe <= 1'b0;
		end else if (trs_r & ack_rise) begin
			ack_r <= sda_s;
		end else if (trs_r & ack_end) begin
			trs_r <= 1'b0;
			tbf_r <= 1'b0;
		end
	end

	// Drive value never changes; only the enable moves
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end

	// Sticky flags; a set in the same cycle beats the clear
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			bcl_r   <= 1'b0;
			wcol_r  <= 1'b0;
			ov_r    <= 1'b0;
			halt_r  <= 1'b0;
			begin_r <= 1'b0;
		end else begin
			bcl_r   <= collide | (bcl_r & ~clr_bcl);
			wcol_r  <= tx_reject | (wcol_r & ~clr_wcol);
			ov_r    <= (rx_store & rbf_r) | (ov_r & ~clr_ov);
			halt_r  <= stop_det | (halt_r & ~clr_halt & ~start_det);
			begin_r <= start_det | (begin_r & ~clr_begin & ~stop_det);
		end
	end

	// Slave address walk and the flags it owns
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_r   <= ISA_IDLE;
			gc_r   <= 1'b0;
			a10_r  <= 1'b0;
			da_r   <= 1'b0;
			rw_r   <= 1'b0;
		end else if (stop_det) begin
			st_r  <= ISA_IDLE;
			gc_r  <= 1'b0;
			a10_r <= 1'b0;
		end else if (start_det) begin
			st_r <= ISA_ADDR;
		end else if (in_addr & gc_hit) begin
			st_r <= ISA_DATA;
			gc_r <= 1'b1;
			da_r <= 1'b0;
			rw_r <= 1'b0;
		end else if (addr_ok) begin
			// Ten-bit read after restart needs no second byte
			rw_r <= byte_in[0];
			if (!ten_mode || (byte_in[0] && a10_r)) begin
				st_r <= ISA_DATA;
				da_r <= 1'b0;
			end else begin
				st_r <= ISA_ADDR2;
			end
		end else if (in_addr2) begin
			st_r  <= addr2_ok ? ISA_DATA : ISA_SKIP;
			a10_r <= a10_r | addr2_ok;
			if (addr2_ok)
				da_r <= 1'b0;
		end else if (in_addr) begin
			st_r <= ISA_SKIP;
		end else if (in_data) begin
			da_r <= 1'b1;
		end else begin
			case (st_r)
				ISA_IDLE, ISA_ADDR, ISA_ADDR2, ISA_DATA, ISA_SKIP: st_r <= st_r;
				default: st_r <= ISA_IDLE;
			endcase
		end
	end

	// Receive buffer; a full buffer keeps its unread byte
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			receive_buffer_r <= 8'h00;
			rbf_r            <= 1'b0;
			rx_pulse         <= 1'b0;
			gcall_pulse      <= 1'b0;
		end else begin
			rx_pulse    <= rx_store & ~rbf_r;
			gcall_pulse <= in_addr & gc_hit;
			if (rx_store & ~rbf_r)
				receive_buffer_r <= byte_in;
			rbf_r <= (rx_store & ~rbf_r) | (rbf_r & ~rd_rx);
		end
	end

	assign slave_state = st_r;

	// Checks
	AST_ACK: assert property (@(posedge core_clk) disable iff (reset)
		(trs_r & ack_rise & ~collide & ~stop_det) |=> (ack_r == $past(sda_s)))
		else $error("ack status not taken from ack bit");
	AST_TRS_END: assert property (@(posedge core_clk) disable iff (reset)
		(trs_r & ack_end & ~stop_det) |=> (!trs_r && !tbf_r))
		else $error("transmit flags not cleared at ack end");
	AST_BCL: assert property (@(posedge core_clk) disable iff (reset)
		collide |=> (bcl_r && !trs_r && !sda_oe))
		else $error("collision not flagged or line not released");
	AST_STOP_CLR: assert property (@(posedge core_clk) disable iff (reset)
		stop_det |=> (!gc_r && !a10_r && halt_r && !begin_r && st_r == ISA_IDLE))
		else $error("stop did not reset address flags");
	AST_WCOL: assert property (@(posedge core_clk) disable iff (reset)
		(wr_tx & busy) |=> (wcol_r && ($past(scl_fall) || $stable(tx_sh_r))))
		else $error("busy write not rejected");
	AST_OV: assert property (@(posedge core_clk) disable iff (reset)
		(rx_store & rbf_r) |=> (ov_r && $stable(receive_buffer_r)))
		else $error("overflow not flagged or buffer overwritten");
	AST_START: assert property (@(posedge core_clk) disable iff (reset)
		start_det |=> (begin_r && !halt_r && st_r == ISA_ADDR))
		else $error("start not recorded");
	AST_RBF: assert property (@(posedge core_clk) disable iff (reset)
		(rx_store & ~rbf_r) |=> (rbf_r && rx_pulse && receive_buffer_r == $past(byte_in)))
		else $error("byte not moved to buffer");
	AST_MASK_HI: assert property (@(posedge core_clk) disable iff (reset)
		(reg_rd & reg_addr == `ISA_OFF_MASK) |=> (reg_rdata == {6'h00, $past(address_mask_r)}))
		else $error("mask upper bits not zero");
	AST_GC_SET: assert property (@(posedge core_clk) disable iff (reset)
		(in_addr & gc_hit) |=> (gc_r && gcall_pulse && st_r == ISA_DATA))
		else $error("general call not taken");
	AST_TEN_SET: assert property (@(posedge core_clk) disable iff (reset)
		addr2_ok |=> (a10_r && !da_r && st_r == ISA_DATA))
		else $error("ten-bit match not recorded");
	AST_DATA_FLAG: assert property (@(posedge core_clk) disable iff (reset)
		in_data |=> da_r)
		else $error("data byte not marked");
	AST_RW_DIR: assert property (@(posedge core_clk) disable iff (reset)
		addr_ok |=> (rw_r == $past(byte_in[0])))
		else $error("direction not taken from address byte");
	AST_TX_SET: assert property (@(posedge core_clk) disable iff (reset)
		(tx_take & ~stop_det) |=> (trs_r && tbf_r && sda_oe == !$past(reg_wdata[7])))
		else $error("transmit write not taken");
	AST_RSVD: assert property (@(posedge core_clk) disable iff (reset)
		(reg_rd & reg_addr == `ISA_OFF_STATUS) |=> (reg_rdata[13:11] == 3'h0))
		else $error("status reserved bits not zero");
endmodule // isa_status

// file: isa_bus_model.sv
// Bus master model that drives the clock and the open-drain data line
`timescale 1ns/1ps
module isa_bus_model (
	output logic       scl,     // Bus clock, stands high between frames
	output logic       sda_low, // High while this side pulls data low
	input  wire logic  sda,     // Resolved data wire
	output logic [7:0] seen     // Byte sampled at clock rises
);
	localparam real Q = 31.25; // Quarter of the 125 ns bit
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		seen = 8'h00;
	end
	// Start or repeated start: data falls while the clock is high
	task automatic start();
		sda_low = 1'b0;
		#(Q) scl = 1'b1;
		#(2 * Q) sda_low = 1'b1;
		#(2 * Q) scl = 1'b0;
	endtask
	// Stop: data rises while the clock is high, then the bus idles
	task automatic stop();
		sda_low = 1'b1;
		#(Q) scl = 1'b1;
		#(2 * Q) sda_low = 1'b0;
		#(2 * Q);
	endtask
	// Eight bits MSB first, then the ack slot; ones release the line
	task automatic byte_x(input logic [7:0] b, input logic ack_low);
		logic [8:0] d;
		d = {b, ~ack_low};
		for (int i = 8; i >= 0; i--) begin
			#(Q) sda_low = ~d[i];
			#(Q) scl = 1'b1;
			if (i > 0) seen = {seen[6:0], sda};
			#(2 * Q) scl = 1'b0;
		end
		// Clock held low a while so the block settles first
		#(4 * Q);
	endtask
endmodule // isa_bus_model

// file: isa_tb.sv
// Self-checking bench: registers, slave address walk, master transmit
`timescale 1ns/1ps
`include "isa_map.svh"
module testbench;
	import isa_pkg::*;
	localparam logic [15:0] f_ack = 16'h8000, f_txa = 16'h4000, f_col = 16'h0400;
	localparam logic [15:0] f_gc = 16'h0200, f_ten = 16'h0100, f_wcol = 16'h0080;
	localparam logic [15:0] f_ovf = 16'h0040, f_dna = 16'h0020, f_halt = 16'h0010;
	localparam logic [15:0] f_beg = 16'h0008, f_rw = 16'h0004, f_rxf = 16'h0002;
	localparam logic [15:0] f_txf = 16'h0001;
	localparam logic [2:0] a_mk = `ISA_OFF_MASK, a_ct = `ISA_OFF_CTRL;
	localparam logic [2:0] a_sa = `ISA_OFF_SADDR, a_tx = `ISA_OFF_TX;
	logic        core_clk = 1'b0;      // System clock
	logic        reset = 1'b1;         // Async reset, high
	logic [2:0]  reg_addr = 3'h0;      // Register index
	logic [15:0] reg_wdata = 16'h0000; // Write data
	logic        reg_wr = 1'b0;        // Write strobe
	logic        reg_rd = 1'b0;        // Read strobe
	logic [15:0] reg_rdata;            // Read data
	logic        scl, bus_low, sda_oe, sda_out, rx_pulse, gcall_pulse; // Pins, pulses
	logic [7:0]  seen, ab, db;         // Wire byte, address byte, data byte
	logic [9:0]  sa, mk;               // Slave address and mask
	logic [15:0] rnd = 16'h0012;       // Random state
	logic        hit;                  // Expected address match
	isa_slave_t  slave_state;          // Slave walk
	int          failures = 0, cmp_count = 0, cyc = 0, rxn = 0, gcn = 0, b0;
	// Open-drain data wire with pull-up
	wire sda = ~(bus_low | (sda_oe & ~sda_out));
	isa_status u_dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.rx_pulse(rx_pulse), .gcall_pulse(gcall_pulse), .slave_state(slave_state));
	isa_bus_model u_bus (.scl(scl), .sda_low(bus_low), .sda(sda), .seen(seen));
	always #5 core_clk = ~core_clk;
	// Pulse counters and hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (rx_pulse === 1'b1) rxn++;
		if (gcall_pulse === 1'b1) gcn++;
		if (cyc == 30000) begin
			failures++;
			report_and_stop();
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Seven-bit match: masked positions are free
	function automatic logic hits(input logic [7:0] a, input logic [9:0] s, input logic [9:0] m);
		return ((a[7:1] ^ s[6:0]) & ~m[6:0]) == 7'h00;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Read is taken at one edge, data stands in the next cycle
	task automatic rd(input logic [2:0] a, input logic [15:0] care, input logic [15:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata & care, exp);
	endtask
	task automatic st(input logic [15:0] care, input logic [15:0] exp);
		rd(`ISA_OFF_STATUS, care, exp);
	endtask
	task automatic report_and_stop();
		if (failures == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		st(16'hFFFF, 16'h0000);
		rd(a_mk, 16'hFFFF, 16'h0000);
		rd(3'h7, 16'hFFFF, 16'h0000);
		wr(a_mk, 16'hFFFF);
		rd(a_mk, 16'hFFFF, 16'h03FF);
		// Random frames: address, data, overflow byte, stop
		wr(a_ct, 16'h0000);
		for (int n = 0; n < 8; n++) begin
			rnd = lfsr(rnd);
			sa = rnd[9:0];
			mk = rnd[9:0] & rnd[15:6];
			rnd = lfsr(rnd);
			ab = {(sa[6:0] & ~mk[6:0]) | (rnd[6:0] & mk[6:0]), 1'b0};
			if (rnd[15] && n > 0) ab = {rnd[7:1], 1'b0};
			db = rnd[14:7];
			hit = hits(ab, sa, mk);
			wr(a_sa, {6'h00, sa});
			wr(a_mk, {6'h00, mk});
			u_bus.start();
			st(f_beg | f_halt, f_beg);
			u_bus.byte_x(ab, 1'b0);
			chk(16'(slave_state), hit ? 16'(ISA_DATA) : 16'(ISA_SKIP));
			if (hit) st(f_dna | f_rw, 16'h0000);
			b0 = rxn;
			u_bus.byte_x(db, 1'b0);
			chk(16'(rxn - b0), {15'h0000, hit});
			st(hit ? f_rxf | f_dna : f_rxf, hit ? f_rxf | f_dna : 16'h0000);
			u_bus.byte_x(~db, 1'b0);
			st(f_ovf, hit ? f_ovf : 16'h0000);
			if (hit) rd(`ISA_OFF_RX, 16'h00FF, {8'h00, db});
			st(f_rxf | f_ovf, hit ? f_ovf : 16'h0000);
			wr(`ISA_OFF_STATUS, 16'h0000);
			st(f_ovf, 16'h0000);
			u_bus.stop();
			st(f_beg | f_halt, f_halt);
		end
		// Read direction from the address byte
		wr(a_mk, 16'h0000);
		u_bus.start();
		u_bus.byte_x({sa[6:0], 1'b1}, 1'b0);
		st(f_rw | f_dna, f_rw);
		u_bus.stop();
		// General call with recognition on, then off
		wr(a_sa, 16'h0055);
		for (int g = 1; g >= 0; g--) begin
			wr(a_ct, g ? 16'h0002 : 16'h0000);
			b0 = gcn;
			u_bus.start();
			u_bus.byte_x(`ISA_GC_ADDR, 1'b0);
			chk(16'(gcn - b0), 16'(g));
			st(f_gc, g ? f_gc : 16'h0000);
			u_bus.stop();
			st(f_gc, 16'h0000);
		end
		// Ten-bit match, low bit masked then required
		rnd = lfsr(rnd);
		wr(a_ct, 16'h0001);
		wr(a_sa, {6'h00, rnd[9:0]});
		for (int m = 1; m >= 0; m--) begin
			wr(a_mk, 16'(m));
			u_bus.start();
			u_bus.byte_x({`ISA_TEN_PFX, rnd[9:8], 1'b0}, 1'b0);
			u_bus.byte_x(rnd[7:0] ^ 8'h01, 1'b0);
			st(f_ten, m ? f_ten : 16'h0000);
			// Restart with a read header: a prior ten-bit match skips the low byte
			u_bus.start();
			u_bus.byte_x({`ISA_TEN_PFX, rnd[9:8], 1'b1}, 1'b0);
			chk(16'(slave_state), m ? 16'(ISA_DATA) : 16'(ISA_ADDR2));
			st(f_ten | f_rw, m ? f_ten | f_rw : f_rw);
			u_bus.stop();
			st(f_ten, 16'h0000);
		end
		// Master transmit with ack, then with nack; busy write refused
		wr(a_ct, 16'h0000);
		for (int k = 0; k < 2; k++) begin
			rnd = lfsr(rnd);
			u_bus.start();
			wr(a_tx, {8'h00, rnd[7:0]});
			st(f_txa | f_txf, f_txa | f_txf);
			wr(a_tx, {8'h00, ~rnd[7:0]});
			st(f_wcol, f_wcol);
			u_bus.byte_x(8'hFF, k == 0);
			chk({8'h00, seen}, {8'h00, rnd[7:0]});
			st(f_ack | f_txa | f_txf, k ? f_ack : 16'h0000);
			wr(`ISA_OFF_STATUS, 16'h0000);
			st(f_wcol, 16'h0000);
			u_bus.stop();
		end
		// Collision on the first bit, sticky across stop
		rnd = lfsr(rnd);
		u_bus.start();
		wr(a_tx, {8'h00, 1'b1, rnd[6:0]});
		u_bus.byte_x({1'b0, rnd[6:0]}, 1'b1);
		st(f_col | f_txa | f_txf, f_col);
		u_bus.stop();
		st(f_col, f_col);
		wr(`ISA_OFF_STATUS, 16'h0000);
		st(f_col, 16'h0000);
		report_and_stop();
	end
endmodule // testbench
